// ==== ddr_sram_port_interface_test.sv ====
// Bench for the DDR burst SRAM port: bursts, lane masks, deselect, stall.
// Assumes dsp_pkg, dsp_port and the controller model dsp_ctl_model.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, a) begin checks++; if ((a) !== (e)) begin n_mismatch++; \
  $display("Error %s expected %h seen %h", nm, e, a); end end
module ddr_sram_port_interface_test;
  import dsp_pkg::*;
  logic clk, rst, sc, stall, pos, wsel_n, rsel_n, oe_n, echo, echo_n;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdat, q;
  logic [LANES-1:0] be_n;
  int checks = 0;
  int n_mismatch = 0;
  int cyc = 0;
  dsp_ctl_model m (.clk_i(clk), .sys_rst_i(rst), .pos_o(pos), .wsel_n_o(wsel_n),
    .rsel_n_o(rsel_n), .addr_o(addr), .data_o(wdat), .be_n_o(be_n));
  // Output phase held low in single clock mode to prove it is unused
  dsp_port DUT (.clk_i(clk), .sys_rst_i(rst), .phase_pos_i(pos),
    .out_phase_pos_i(pos & ~sc), .single_clock_i(sc), .dll_disable_i(1'b1),
    .write_port_sel_n_i(wsel_n), .read_port_sel_n_i(rsel_n), .addr_i(addr),
    .write_input_bus_i(wdat), .byte_lane_enable_n_i(be_n), .read_output_bus_o(q),
    .read_output_oe_n_o(oe_n), .echo_strobe_o(echo), .echo_strobe_n_o(echo_n),
    .rd_stall_i(stall));
  // ==========================================================
  // Shared tasks
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d0, d1,
      input logic [LANES-1:0] e0, e1);
    m.acc(1'b1, 1'b0, ~a, a, d0, d1, e0, e1);
  endtask
  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] lo, hi,
      input int st);
    int n;
    n = 0;
    stall = (st != 0);
    fork
      m.acc(1'b0, 1'b1, a, ~a, '0, '0, LANE_OFF, LANE_OFF);
      begin
        repeat (st) @(negedge clk);
        stall = 1'b0;
      end
      begin
        while (oe_n !== 1'b0 && n < 20) begin
          @(negedge clk);
          n++;
        end
        `CHK("first word", lo, q)
        @(negedge clk);
        `CHK("second word", hi, q)
        repeat (3) @(negedge clk);
        `CHK("output float", 1'b1, oe_n)
      end
    join
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_basic();
    wr(19'h3FFFF, 18'h2A5A5, 18'h15A5A, 2'h0, 2'h0);
    wr(19'h00000, 18'h3FFFF, 18'h3FFFF, 2'h0, 2'h0);
    rd_chk(19'h3FFFF, 18'h2A5A5, 18'h15A5A, 0);
    rd_chk(19'h00000, 18'h3FFFF, 18'h3FFFF, 0);
    $display("test basic done");
  endtask
  task automatic t_lanes();
    wr(19'h00000, 18'h00000, 18'h00000, 2'h2, 2'h1);
    rd_chk(19'h00000, 18'h3FE00, 18'h001FF, 0);
    $display("test lanes done");
  endtask
  task automatic t_desel();
    m.acc(1'b0, 1'b0, 19'h3FFFF, 19'h3FFFF, 18'h00000, 18'h00000, 2'h0, 2'h0);
    rd_chk(19'h3FFFF, 18'h2A5A5, 18'h15A5A, 0);
    $display("test deselect done");
  endtask
  task automatic t_stall();
    rd_chk(19'h00000, 18'h3FE00, 18'h001FF, 6);
    $display("test stall done");
  endtask
  task automatic t_reset();
    @(negedge clk);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    `CHK("bus in reset", DATA_RST, q)
    `CHK("float in reset", 1'b1, oe_n)
    `CHK("echo in reset", 1'b0, echo)
    `CHK("echo bar in reset", 1'b1, echo_n)
    rst = 1'b0;
    // Storage survives reset and the first access follows at once
    rd_chk(19'h00000, 18'h3FE00, 18'h001FF, 0);
    `CHK("echo pair", ~echo, echo_n)
    $display("test reset done");
  endtask
  task automatic t_single();
    sc = 1'b1;
    rd_chk(19'h3FFFF, 18'h2A5A5, 18'h15A5A, 0);
    sc = 1'b0;
    $display("test single clock done");
  endtask
  // ==========================================================
  // Clock, reset, sequence and hang guard
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      n_mismatch++;
      wrap_up();
    end
  end
  initial begin
    rst = 1'b1;
    sc = 1'b0;
    stall = 1'b0;
    repeat (4) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    t_basic();
    t_lanes();
    t_desel();
    t_stall();
    t_reset();
    t_single();
    wrap_up();
  end
endmodule
`default_nettype wire

// ==== dsp_buf2.sv ====
// Two-entry valid/ready buffer for read data words.
// Assumes a single clock and an active-high asynchronous reset.
`timescale 1ns/100ps
`default_nettype none
module dsp_buf2 #(
  parameter int W = 18
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  // Drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);
  logic [W-1:0] mem [2];
  logic [W-1:0] next_mem [2];
  logic rd_ptr, wr_ptr, next_rd_ptr, next_wr_ptr;
  logic [1:0] count, next_count;
  logic push, pop;

  assign in_ready_o = (count != 2'h2);
  assign out_valid_o = (count != 2'h0);
  assign out_data_o = mem[rd_ptr];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_comb begin
    next_mem = mem;
    next_rd_ptr = rd_ptr;
    next_wr_ptr = wr_ptr;
    next_count = count;
    if (push) begin
      next_mem[wr_ptr] = in_data_i;
      next_wr_ptr = ~wr_ptr;
    end
    if (pop) begin
      next_rd_ptr = ~rd_ptr;
    end
    if (push && !pop) begin
      next_count = count + 2'h1;
    end else if (pop && !push) begin
      next_count = count - 2'h1;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      mem[0] <= '0;
      mem[1] <= '0;
      rd_ptr <= 1'b0;
      wr_ptr <= 1'b0;
      count <= 2'h0;
    end else begin
      mem <= next_mem;
      rd_ptr <= next_rd_ptr;
      wr_ptr <= next_wr_ptr;
      count <= next_count;
    end
  end

  count_bound_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    count <= 2'h2) else $error("buffer count over depth");
endmodule
`default_nettype wire

// ==== dsp_ctl_model.sv ====
// Controller model for the DDR burst SRAM port: phases, selects, address, data.
// Assumes the bench calls acc() and holds the reset; drives on falling edges.
`timescale 1ns/100ps
`default_nettype none
module dsp_ctl_model
  import dsp_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Link to the device
  output logic pos_o,
  output logic wsel_n_o,
  output logic rsel_n_o,
  output logic [dsp_pkg::ADDR_W-1:0] addr_o,
  output logic [dsp_pkg::DATA_W-1:0] data_o,
  output logic [dsp_pkg::LANES-1:0] be_n_o
);
  import dsp_pkg::*;
  initial begin
    pos_o = 1'b0;
    wsel_n_o = 1'b1;
    rsel_n_o = 1'b1;
    addr_o = '0;
    data_o = '0;
    be_n_o = LANE_OFF;
  end
  // ==========================================================
  // Phase pair, no skew modelled
  always @(negedge clk_i) begin
    pos_o <= sys_rst_i ? 1'b0 : ~pos_o;
  end
  // ==========================================================
  // One access slot: positive phase then negative phase
  task automatic acc(input logic w, input logic r, input logic [ADDR_W-1:0] ra, wa,
      input logic [DATA_W-1:0] d0, d1, input logic [LANES-1:0] e0, e1);
    @(negedge clk_i);
    while (pos_o) @(negedge clk_i);
    wsel_n_o <= ~w;
    rsel_n_o <= ~r;
    addr_o <= ra;
    data_o <= d0;
    be_n_o <= e0;
    @(negedge clk_i);
    wsel_n_o <= 1'b1;
    rsel_n_o <= 1'b1;
    addr_o <= wa;
    data_o <= d1;
    be_n_o <= e1;
    @(negedge clk_i);
    // Released lines show the inverse so stale values never pass
    addr_o <= ~wa;
    data_o <= ~d1;
    be_n_o <= ~e1;
  endtask
endmodule
`default_nettype wire

// ==== dsp_pkg.sv ====
// Package for the double-data-rate burst SRAM port model.
// Assumes one system clock; each phase of the link is one clk_i cycle.
package dsp_pkg;
  // ==========================================================
  // Widths
  localparam int DATA_W = 18;
  localparam int LANE_W = 9;
  localparam int LANES = 2;
  localparam int ADDR_W = 19;
  localparam int BUF_DEPTH = 2;
  // Reset values
  localparam logic [DATA_W-1:0] DATA_RST = 18'h00000;
  localparam logic [LANES-1:0] LANE_OFF = 2'h3;
  // Timing: one link phase per clock cycle at 10 ns
  localparam int CLK_NS = 10;
  localparam int PHASE_NS = 10;
  localparam int PHASE_CYC = (PHASE_NS + CLK_NS - 1) / CLK_NS;
  // Echo strobe divider: half period in cycles
  localparam logic [3:0] ECHO_HALF = 4'h1;
endpackage

// ==== dsp_port.sv ====
// Device-side logic of a separate-I/O DDR burst SRAM, x18 organisation.
// Assumes the link runs on clk_i: the positive input phase is flagged by
// phase_pos_i, the negative phase is the other cycle; output phases too.
`timescale 1ns/100ps
`default_nettype none
module dsp_port
  import dsp_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Phase markers
  input wire logic phase_pos_i,
  input wire logic out_phase_pos_i,
  input wire logic single_clock_i,
  input wire logic dll_disable_i,
  // Command and address
  input wire logic write_port_sel_n_i,
  input wire logic read_port_sel_n_i,
  input wire logic [dsp_pkg::ADDR_W-1:0] addr_i,
  // Write port
  input wire logic [dsp_pkg::DATA_W-1:0] write_input_bus_i,
  input wire logic [dsp_pkg::LANES-1:0] byte_lane_enable_n_i,
  // Read port
  output logic [dsp_pkg::DATA_W-1:0] read_output_bus_o,
  output logic read_output_oe_n_o,
  output logic echo_strobe_o,
  output logic echo_strobe_n_o,
  // Drain side stall for read words
  input wire logic rd_stall_i
);
  import dsp_pkg::*;

  // ==========================================================
  // Storage: two halves, the first beat goes to half_lo, the second to half_hi
  localparam int DEPTH = 1 << (ADDR_W - 1);
  logic [DATA_W-1:0] half_lo [DEPTH];
  logic [DATA_W-1:0] half_hi [DEPTH];

  // ==========================================================
  // Write capture
  logic wr_pend, next_wr_pend;
  logic [DATA_W-1:0] wr_beat0, next_wr_beat0;
  logic [LANES-1:0] wr_en0_n, next_wr_en0_n;
  logic commit;
  logic [DATA_W-1:0] beat1;
  logic [LANES-1:0] en1_n;

  always_comb begin
    next_wr_pend = 1'b0;
    next_wr_beat0 = wr_beat0;
    next_wr_en0_n = wr_en0_n;
    commit = 1'b0;
    beat1 = write_input_bus_i;
    en1_n = byte_lane_enable_n_i;
    if (phase_pos_i) begin
      // Only positive phase may start an access
      if (!write_port_sel_n_i) begin
        next_wr_pend = 1'b1;
        next_wr_beat0 = write_input_bus_i;
        next_wr_en0_n = byte_lane_enable_n_i;
      end
      // Deselected: data and lane enables are not looked at
    end else if (wr_pend) begin
      // Write address is used straight from the negative phase
      commit = 1'b1;
    end
    // Address on a negative phase with no write is dropped
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wr_pend <= 1'b0;
      wr_beat0 <= DATA_RST;
      wr_en0_n <= LANE_OFF;
    end else begin
      wr_pend <= next_wr_pend;
      wr_beat0 <= next_wr_beat0;
      wr_en0_n <= next_wr_en0_n;
    end
  end

  // Array write: both beats land in the same cycle, one per half
  always_ff @(posedge clk_i) begin
    if (commit) begin
      for (int l = 0; l < LANES; l++) begin
        if (!wr_en0_n[l]) begin
          half_lo[addr_i[ADDR_W-2:0]][l*LANE_W +: LANE_W] <=
            wr_beat0[l*LANE_W +: LANE_W];
        end
        if (!en1_n[l]) begin
          half_hi[addr_i[ADDR_W-2:0]][l*LANE_W +: LANE_W] <=
            beat1[l*LANE_W +: LANE_W];
        end
      end
    end
  end

  // ==========================================================
  // Read: address on positive phase, two words queued
  logic rd_second, next_rd_second;
  logic [ADDR_W-2:0] rd_row, next_rd_row;
  logic q_valid;
  logic q_ready;
  logic [DATA_W-1:0] q_data;
  logic b_valid;
  logic b_ready;
  logic [DATA_W-1:0] b_data;

  always_comb begin
    next_rd_second = rd_second;
    next_rd_row = rd_row;
    q_valid = 1'b0;
    q_data = half_hi[rd_row];
    if (rd_second) begin
      q_valid = 1'b1;
      if (q_ready) begin
        next_rd_second = 1'b0;
      end
    end else if (phase_pos_i && !read_port_sel_n_i) begin
      next_rd_row = addr_i[ADDR_W-2:0];
      q_valid = 1'b1;
      q_data = half_lo[addr_i[ADDR_W-2:0]];
      if (q_ready) begin
        next_rd_second = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rd_second <= 1'b0;
      rd_row <= '0;
    end else begin
      rd_second <= next_rd_second;
      rd_row <= next_rd_row;
    end
  end

  dsp_buf2 #(
    .W(DATA_W)
  ) u_buf (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .in_valid_i(q_valid),
    .in_ready_o(q_ready),
    .in_data_i(q_data),
    .out_valid_o(b_valid),
    .out_ready_i(b_ready),
    .out_data_o(b_data)
  );

  // ==========================================================
  // Output driver: one word per output phase
  logic [DATA_W-1:0] next_q;
  logic next_oe_n;
  logic out_edge;

  // In single clock mode the input phase times the outputs
  assign out_edge = 1'b1;
  assign b_ready = out_edge && !rd_stall_i;

  always_comb begin
    next_q = read_output_bus_o;
    next_oe_n = read_output_oe_n_o;
    if (b_valid && b_ready) begin
      next_q = b_data;
      next_oe_n = 1'b0;
    end else if (single_clock_i ? phase_pos_i : out_phase_pos_i) begin
      // Float on a positive output phase that sends no word, even while stalled words wait
      next_oe_n = 1'b1;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      read_output_bus_o <= DATA_RST;
      read_output_oe_n_o <= 1'b1;
    end else begin
      read_output_bus_o <= next_q;
      read_output_oe_n_o <= next_oe_n;
    end
  end

  // ==========================================================
  // Echo strobe: free running, follows the output clock pair.
  // With the DLL off its phase is not trimmed; the controller copes.
  logic next_echo;
  always_comb begin
    next_echo = single_clock_i ? phase_pos_i : out_phase_pos_i;
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      echo_strobe_o <= 1'b0;
      echo_strobe_n_o <= 1'b1;
    end else begin
      echo_strobe_o <= next_echo;
      echo_strobe_n_o <= ~next_echo;
    end
  end

  // ==========================================================
  // Drive watch: cycles the bus stays driven with nothing left to send
  logic [1:0] idle_drive, next_idle_drive;

  always_comb begin
    next_idle_drive = 2'h0;
    if (!read_output_oe_n_o && !b_valid) begin
      next_idle_drive = (idle_drive == 2'h3) ? idle_drive : idle_drive + 2'h1;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      idle_drive <= 2'h0;
    end else begin
      idle_drive <= next_idle_drive;
    end
  end

  // ==========================================================
  // Checks
  write_start_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (phase_pos_i && !write_port_sel_n_i) |=> wr_pend)
    else $error("write select did not start a write");
  write_ignore_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (phase_pos_i && write_port_sel_n_i) |=> !wr_pend)
    else $error("deselected write port started a write");
  write_commit_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    commit |-> $past(phase_pos_i) && !phase_pos_i)
    else $error("write committed outside second beat");
  commit_due_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (wr_pend && !phase_pos_i) |-> commit)
    else $error("pending write not committed");
  beat_capture_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (phase_pos_i && !write_port_sel_n_i) |=> wr_beat0 == $past(write_input_bus_i))
    else $error("first write beat not captured");
  lane_capture_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (phase_pos_i && !write_port_sel_n_i) |=> wr_en0_n == $past(byte_lane_enable_n_i))
    else $error("first beat lane enables not captured");
  lane_keep_lo_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (commit && wr_en0_n[0]) |=> half_lo[$past(addr_i[ADDR_W-2:0])][LANE_W-1:0] ==
      $past(half_lo[addr_i[ADDR_W-2:0]][LANE_W-1:0]))
    else $error("disabled lane of first beat was written");
  lane_keep_hi_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (commit && en1_n[1]) |=> half_hi[$past(addr_i[ADDR_W-2:0])][DATA_W-1:LANE_W] ==
      $past(half_hi[addr_i[ADDR_W-2:0]][DATA_W-1:LANE_W]))
    else $error("disabled lane of second beat was written");
  read_burst_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (phase_pos_i && !read_port_sel_n_i && !rd_second && q_ready) |=> rd_second)
    else $error("read burst second word missing");
  read_second_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (rd_second && q_ready) |=> !rd_second)
    else $error("read burst ran past two words");
  read_start_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (!rd_second && !(phase_pos_i && !read_port_sel_n_i)) |-> !q_valid)
    else $error("read word queued without select");
  drive_word_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (b_valid && b_ready) |=> !read_output_oe_n_o && read_output_bus_o == $past(b_data))
    else $error("read word not driven");
  stall_hold_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (b_valid && !b_ready) |=> $stable(read_output_bus_o))
    else $error("read bus moved while stalled");
  float_idle_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (!b_valid && !single_clock_i && out_phase_pos_i) |=> read_output_oe_n_o)
    else $error("output not floated after deselect");
  float_single_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (!b_valid && single_clock_i && phase_pos_i) |=> read_output_oe_n_o)
    else $error("output not floated in single clock mode");
  float_soon_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    idle_drive != 2'h3)
    else $error("bus left driven after the burst");
  echo_pair_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    echo_strobe_o != echo_strobe_n_o)
    else $error("echo strobes not complementary");
  echo_follow_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !$past(sys_rst_i) |-> echo_strobe_o == $past(single_clock_i ? phase_pos_i : out_phase_pos_i))
    else $error("echo strobe does not follow the output phase");
endmodule
`default_nettype wire
